//--- src/sas_axis.sv
// One axis: fault latch, enable gating, limit polarity and current selection.
`timescale 1ns/1ps
module sas_axis
  import sas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic err_clr_i,
  input wire logic run_ok_i,
  input wire logic enable_i,
  input wire sas_fault_t fault_i,
  input wire logic [1:0] limit_raw_i,
  input wire logic [1:0] limit_no_i,
  input wire sas_cur_t cur_i,
  input wire logic moving_i,
  input wire logic accel_i,
  input wire logic [MSTEP_W-1:0] mstep_i,
  output logic stage_on_o,
  output logic fault_o,
  output logic [1:0] limit_o,
  output logic [7:0] cur_o,
  output logic [MSTEP_W-1:0] mstep_o
);

  logic fault_q;
  logic fault_d;
  logic fault_now;
  logic [1:0] limit_act;
  logic [MSTEP_W-1:0] mstep_lim;

  assign fault_now = fault_i.short_circuit | fault_i.over_temp | fault_i.under_volt;
  // A new fault wins over a clear in the same cycle.
  assign fault_d = fault_now | (fault_q & ~err_clr_i);
  // Closed contacts read 1; normally closed reports an open contact as active.
  assign limit_act = limit_no_i ^ ~limit_raw_i;
  assign mstep_lim = (mstep_i > MSTEP_MAX) ? MSTEP_MAX : mstep_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
      stage_on_o <= 1'b0;
      limit_o <= 2'b00;
      cur_o <= 8'h00;
      mstep_o <= 4'h0;
    end else begin
      fault_q <= fault_d;
      stage_on_o <= enable_i & run_ok_i & ~fault_d;
      limit_o <= limit_act;
      cur_o <= sas_clamp(sas_sel_cur(cur_i, moving_i, accel_i));
      mstep_o <= mstep_lim;
    end
  end

  assign fault_o = fault_q;

endmodule

//--- src/sas_pkg.sv
// Package with register map, field layouts and timing constants of the axis supervisor.
package sas_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RESTART_DELAY_MS = 3000;
  localparam int unsigned RESTART_CYCLES = (CLK_HZ / 1000) * RESTART_DELAY_MS;
  localparam int unsigned REST_W = 27;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_CUR_A0 = 8'h10;
  localparam logic [7:0] OFF_CUR_A1 = 8'h14;
  localparam logic [7:0] OFF_MSTEP = 8'h18;

  // ------------------------------------------------------------
  // Field positions, widths, limits and reset value
  // ------------------------------------------------------------
  localparam int unsigned CTRL_LIM_NO_LSB = 0;
  localparam int unsigned CTRL_HOST_RUN = 4;
  localparam int unsigned CTRL_HOST_CALL = 5;
  localparam int unsigned CTRL_FW_BUSY = 6;
  localparam int unsigned CTRL_ERR_CLR = 7;
  localparam int unsigned NUM_AXES = 2;
  localparam int unsigned CUR_W = 8;
  localparam int unsigned MSTEP_W = 4;
  localparam logic [3:0] MSTEP_MAX = 4'h8;
  localparam logic [7:0] CUR_MAX = 8'h23;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Interrupt status bits.
  localparam int unsigned IRQ_FAULT0 = 0;
  localparam int unsigned IRQ_FAULT1 = 1;
  localparam int unsigned IRQ_LIMIT0 = 2;
  localparam int unsigned IRQ_LIMIT1 = 3;
  localparam int unsigned IRQ_LOCAL = 4;
  localparam int unsigned IRQ_READY = 5;
  localparam int unsigned IRQ_W = 6;

  // Current setpoints of one axis in tenths of an ampere.
  typedef struct packed {
    logic [7:0] boost;
    logic [7:0] stop;
    logic [7:0] run;
  } sas_cur_t;

  // Power-stage fault inputs of one axis.
  typedef struct packed {
    logic short_circuit;
    logic over_temp;
    logic under_volt;
  } sas_fault_t;

  typedef enum logic [2:0] {
    ST_LED_GREEN = 3'b001,
    ST_LED_RED = 3'b010,
    ST_LED_ORANGE = 3'b100
  } sas_led_t;

  typedef enum logic [2:0] {
    OP_WAIT = 3'b001,
    OP_REMOTE = 3'b010,
    OP_LOCAL = 3'b100
  } sas_op_t;

  // Current in use for one axis.
  function automatic logic [7:0] sas_sel_cur(input sas_cur_t c, input logic moving,
                                            input logic accel);
    if (!moving) begin
      return c.stop;
    end
    return accel ? c.boost : c.run;
  endfunction

  // Clamp a setpoint to the peak supported current.
  function automatic logic [7:0] sas_clamp(input logic [7:0] v);
    return (v > CUR_MAX) ? CUR_MAX : v;
  endfunction

endpackage

//--- src/sas_top.sv
// Two-axis stepper supervisor with APB registers, mode switch, restart delay and status LED.
//
// Behaviour
// - A short, overtemperature or undervoltage on an axis switches its power stage off.
// - Each axis divides a full step into microsteps down to one 256th of a step.
// - Each axis has two limit inputs, normally closed by default or normally open.
// - The stages are enabled by a dedicated enable input, independent of step pulses.
// - Run, stop and boost currents are set per axis, each up to 3.5 A peak.
// - In remote mode host transfers and single host-driven runs are allowed.
// - Switching to local mode starts the stored autostart program.
// - In local mode the program runs alone and may call the host for data.
// - The reset push-button clears pending error indications.
// - After reset release the device waits about three seconds before running.
// - The device address comes from a sixteen-position rotary switch.
// - The address switch is sampled only at power-on or reset.
// - The LED is green when ready, red on error and orange while updating firmware.
`timescale 1ns/1ps
module sas_top
  import sas_pkg::*;
#(
  parameter int unsigned RESTART_CYC = RESTART_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_button_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enable_connector_i,
  input wire logic local_mode_i,
  input wire logic [3:0] addr_switch_i,
  input wire sas_fault_t [NUM_AXES-1:0] fault_i,
  input wire logic [2*NUM_AXES-1:0] limit_raw_i,
  input wire logic [NUM_AXES-1:0] moving_i,
  input wire logic [NUM_AXES-1:0] accel_i,
  output logic [NUM_AXES-1:0] stage_on_o,
  output logic [2*NUM_AXES-1:0] limit_o,
  output logic [8*NUM_AXES-1:0] cur_o,
  output logic [2*MSTEP_W-1:0] mstep_o,
  output logic [3:0] dev_addr_o,
  output logic prog_start_o,
  output logic local_run_o,
  output logic host_run_o,
  output logic host_call_o,
  output logic led_green_o,
  output logic led_red_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // Restart delay and address capture
  // ------------------------------------------------------------
  // The push-button restarts the delay, address capture and mode like the system reset, and also clears latched errors.
  logic any_rst;
  logic [REST_W-1:0] wait_q;
  logic ready;
  logic addr_taken_q;
  sas_op_t op_q;
  sas_op_t op_d;
  logic local_q;

  assign any_rst = rst_i | reset_button_i;
  assign ready = (wait_q == REST_W'(RESTART_CYC));

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      wait_q <= '0;
    end else if (!ready) begin
      wait_q <= wait_q + REST_W'(1);
    end
  end

  // The switch is caught on the first clock after release, never under reset.
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      addr_taken_q <= 1'b0;
      dev_addr_o <= 4'h0;
    end else if (!addr_taken_q) begin
      addr_taken_q <= 1'b1;
      dev_addr_o <= addr_switch_i;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] ist_d;
  logic [IRQ_W-1:0] imask_q;
  sas_cur_t [NUM_AXES-1:0] cur_q;
  logic [2*MSTEP_W-1:0] mstep_q;
  logic [NUM_AXES-1:0] fault;
  logic [2*NUM_AXES-1:0] limit_q;
  logic ready_q;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [IRQ_W-1:0] ev;
  logic err_clr;

  assign wr_en = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign rd_hit = (paddr_i == OFF_CTRL) | (paddr_i == OFF_STATUS) |
                  (paddr_i == OFF_IRQ_STAT) | (paddr_i == OFF_IRQ_MASK) |
                  (paddr_i == OFF_CUR_A0) | (paddr_i == OFF_CUR_A1) |
                  (paddr_i == OFF_MSTEP);
  assign pslverr_o = psel_i & penable_i & ~rd_hit;

  assign rd_val =
    (paddr_i == OFF_CTRL) ? {24'h00_0000, ctrl_q} :
    (paddr_i == OFF_STATUS) ? {16'h0000, dev_addr_o, local_q, ready,
                              limit_o, stage_on_o, 2'b00, fault} :
    (paddr_i == OFF_IRQ_STAT) ? {26'h000_0000, ist_q} :
    (paddr_i == OFF_IRQ_MASK) ? {26'h000_0000, imask_q} :
    (paddr_i == OFF_CUR_A0) ? {8'h00, cur_q[0]} :
    (paddr_i == OFF_CUR_A1) ? {8'h00, cur_q[1]} :
    (paddr_i == OFF_MSTEP) ? {24'h00_0000, mstep_q} : 32'h0000_0000;

  // Software error clear is a self-clearing write strobe.
  assign err_clr = reset_button_i |
                   (wr_en & (paddr_i == OFF_CTRL) & pwdata_i[CTRL_ERR_CLR]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      imask_q <= '0;
      cur_q <= '0;
      mstep_q <= '0;
      prdata_o <= 32'h0000_0000;
    end else begin
      prdata_o <= rd_val;
      if (wr_en && paddr_i == OFF_CTRL) begin
        ctrl_q <= {1'b0, pwdata_i[6:0]};
      end
      if (wr_en && paddr_i == OFF_IRQ_MASK) begin
        imask_q <= pwdata_i[IRQ_W-1:0];
      end
      if (wr_en && paddr_i == OFF_CUR_A0) begin
        cur_q[0] <= pwdata_i[23:0];
      end
      if (wr_en && paddr_i == OFF_CUR_A1) begin
        cur_q[1] <= pwdata_i[23:0];
      end
      if (wr_en && paddr_i == OFF_MSTEP) begin
        mstep_q <= pwdata_i[2*MSTEP_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Axes
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      sas_axis u_axis (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .err_clr_i(err_clr),
        .run_ok_i(ready),
        .enable_i(enable_connector_i),
        .fault_i(fault_i[g]),
        .limit_raw_i(limit_raw_i[2*g+1:2*g]),
        .limit_no_i(ctrl_q[CTRL_LIM_NO_LSB+2*g+1:CTRL_LIM_NO_LSB+2*g]),
        .cur_i(cur_q[g]),
        .moving_i(moving_i[g]),
        .accel_i(accel_i[g]),
        .mstep_i(mstep_q[MSTEP_W*g+MSTEP_W-1:MSTEP_W*g]),
        .stage_on_o(stage_on_o[g]),
        .fault_o(fault[g]),
        .limit_o(limit_o[2*g+1:2*g]),
        .cur_o(cur_o[8*g+7:8*g]),
        .mstep_o(mstep_o[MSTEP_W*g+MSTEP_W-1:MSTEP_W*g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Operating mode
  // ------------------------------------------------------------
  // The program starts only on a remote-to-local change, not when powered up in local.
  always_comb begin
    op_d = op_q;
    case (op_q)
      OP_WAIT: begin
        if (ready) begin
          op_d = local_mode_i ? OP_LOCAL : OP_REMOTE;
        end
      end
      OP_REMOTE: begin
        if (local_mode_i) begin
          op_d = OP_LOCAL;
        end
      end
      OP_LOCAL: begin
        if (!local_mode_i) begin
          op_d = OP_REMOTE;
        end
      end
      default: op_d = OP_WAIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      op_q <= OP_WAIT;
      local_q <= 1'b0;
      prog_start_o <= 1'b0;
      local_run_o <= 1'b0;
      host_run_o <= 1'b0;
      host_call_o <= 1'b0;
    end else begin
      op_q <= op_d;
      local_q <= local_mode_i;
      prog_start_o <= (op_q == OP_REMOTE) & (op_d == OP_LOCAL);
      local_run_o <= (op_d == OP_LOCAL);
      host_run_o <= (op_d == OP_REMOTE) & ctrl_q[CTRL_HOST_RUN];
      host_call_o <= (op_d == OP_LOCAL) & ctrl_q[CTRL_HOST_CALL];
    end
  end

  // ------------------------------------------------------------
  // Interrupts and LED
  // ------------------------------------------------------------
  logic ready_rise;
  assign ready_rise = ready & ~ready_q;
  assign ev = {ready_rise, prog_start_o, |(limit_o[3:2] & ~limit_q[3:2]),
               |(limit_o[1:0] & ~limit_q[1:0]), fault[1], fault[0]};
  // A new event wins over a write-one-to-clear in the same cycle.
  assign ist_d = ev | (ist_q & ~({IRQ_W{wr_en & (paddr_i == OFF_IRQ_STAT)}} &
                                 pwdata_i[IRQ_W-1:0]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
      limit_q <= '0;
      ready_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      ist_q <= ist_d;
      limit_q <= limit_o;
      ready_q <= ready;
      irq_o <= |(ist_d & imask_q);
    end
  end

  sas_led_t led;
  assign led = (|fault) ? ST_LED_RED :
               ctrl_q[CTRL_FW_BUSY] ? ST_LED_ORANGE : ST_LED_GREEN;
  assign led_green_o = (led == ST_LED_GREEN) | (led == ST_LED_ORANGE);
  assign led_red_o = (led == ST_LED_RED) | (led == ST_LED_ORANGE);

endmodule

//--- tb/sas_monitor.sv
// Concurrent checks on the ports of the axis supervisor.
`timescale 1ns/1ps
module sas_monitor
  import sas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_button_i,
  input wire logic psel_i,
  input wire logic enable_connector_i,
  input wire sas_fault_t [NUM_AXES-1:0] fault_i,
  input wire logic [NUM_AXES-1:0] stage_on_o,
  input wire logic [8*NUM_AXES-1:0] cur_o,
  input wire logic [2*MSTEP_W-1:0] mstep_o,
  input wire logic [3:0] dev_addr_o,
  input wire logic prog_start_o,
  input wire logic led_red_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fault0;
    |fault_i[0];
  endsequence
  sequence s_quiet;
    (!reset_button_i && !psel_i)[*4];
  endsequence
  sequence s_pulse;
    prog_start_o ##1 !prog_start_o;
  endsequence
  AST_FAULT_OFF: assert property (s_fault0 |=> !stage_on_o[0])
    else $error("stage 0 on after fault");
  AST_FAULT_HOLD: assert property (s_fault0 ##1 s_quiet |-> !stage_on_o[0])
    else $error("fault latch lost");
  AST_FAULT_RED: assert property ((|fault_i) |=> led_red_o)
    else $error("no red after fault");
  AST_ENABLE: assert property (!enable_connector_i |=> stage_on_o == 2'b00)
    else $error("stage on without enable");
  AST_CUR_PEAK: assert property (cur_o[7:0] <= CUR_MAX && cur_o[15:8] <= CUR_MAX)
    else $error("current above peak");
  AST_MSTEP_FINE: assert property (mstep_o[3:0] <= MSTEP_MAX && mstep_o[7:4] <= MSTEP_MAX)
    else $error("microstep code too fine");
  AST_ADDR_HOLD: assert property (!reset_button_i && !$past(reset_button_i) && !$past(rst_i)
    |=> $stable(dev_addr_o))
    else $error("address moved outside reset");
  AST_PROG_PULSE: assert property ($rose(prog_start_o) |-> s_pulse)
    else $error("start pulse too long");
endmodule

bind sas_top sas_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .reset_button_i(reset_button_i),
  .psel_i(psel_i), .enable_connector_i(enable_connector_i), .fault_i(fault_i),
  .stage_on_o(stage_on_o), .cur_o(cur_o), .mstep_o(mstep_o), .dev_addr_o(dev_addr_o),
  .prog_start_o(prog_start_o), .led_red_o(led_red_o));

//--- tb/sas_plant.sv
// Model of the motors and limit switches around the supervisor.
`timescale 1ns/1ps
module sas_plant (
  input wire logic clk_i,
  input wire logic [1:0] cmd_i,
  input wire logic [3:0] open_i,
  input wire logic [1:0] stage_on_i,
  output logic [1:0] moving_o = 2'b00,
  output logic [1:0] accel_o = 2'b00,
  output logic [3:0] limit_raw_o
);
  // Closed contacts read high; an opened switch lets its line fall.
  assign limit_raw_o = ~open_i;
  // A motor whose stage is off cannot follow a motion command.
  always_ff @(posedge clk_i) begin
    moving_o <= {2{cmd_i != 2'b00}} & stage_on_i;
    accel_o <= {2{cmd_i == 2'b10}} & stage_on_i;
  end
endmodule

//--- tb/tb_stepper_axis_supervisor.sv
// Self-checking bench of the two-axis stepper supervisor.
`timescale 1ns/1ps
module tb_stepper_axis_supervisor;
  import sas_pkg::*;
  localparam int unsigned RC = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, btn = 1'b0, enable = 1'b1, local_mode = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  sas_fault_t [1:0] fault = '0;
  logic [1:0] cmd = 2'b00;
  logic [3:0] open = 4'h0;
  logic [1:0] moving, accel, stage_on;
  logic [3:0] sw, limit_raw, limit, dev_addr, addr0, lim_exp;
  logic [15:0] cur;
  logic [7:0] mstep, run_val, ec;
  logic [31:0] prdata;
  logic pready, slverr, prog_start, local_run, host_run, host_call, green, red, irq;
  logic [31:0] expq[$];
  int bad_count = 0;
  int tests_run = 0;
  int t;
  integer seed = 52352;
  always #25 clk_i = ~clk_i;
  sas_top #(.RESTART_CYC(RC)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .reset_button_i(btn),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr),
    .enable_connector_i(enable), .local_mode_i(local_mode), .addr_switch_i(sw),
    .fault_i(fault), .limit_raw_i(limit_raw), .moving_i(moving), .accel_i(accel),
    .stage_on_o(stage_on), .limit_o(limit), .cur_o(cur), .mstep_o(mstep),
    .dev_addr_o(dev_addr), .prog_start_o(prog_start), .local_run_o(local_run),
    .host_run_o(host_run), .host_call_o(host_call), .led_green_o(green),
    .led_red_o(red), .irq_o(irq));
  sas_plant i_plant (.clk_i(clk_i), .cmd_i(cmd), .open_i(open), .stage_on_i(stage_on),
    .moving_o(moving), .accel_o(accel), .limit_raw_o(limit_raw));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Ends on a falling edge so that registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      w++;
    end while (pready !== 1'b1 && w < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (w == 20) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] st(input logic [1:0] s, input logic [1:0] f);
    return {16'h0000, addr0, local_mode, 1'b1, lim_exp, s, 2'b00, f};
  endfunction
  always @(posedge clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      chk("prdata", prdata, expq.size() > 0 ? expq.pop_front() : 32'hDEAD_BEEF);
    end
    if (psel && penable && pready === 1'b1) begin
      chk("pslverr_o", 32'(slverr), 32'(paddr > OFF_MSTEP || paddr[1:0] != 2'b00));
    end
  end
  initial begin
    addr0 = 4'($random(seed));
    run_val = 8'($random(seed));
    lim_exp = 4'h0;
    sw = addr0;
    cyc(1);
    @(posedge clk_i) rst_i <= 1'b0;
    cyc(RC + 5);
    @(posedge clk_i) sw <= ~addr0;
    cyc(2);
    chk("dev_addr_o", 32'(dev_addr), 32'(addr0));
    rd(OFF_STATUS, st(2'b11, 2'b00));
    rd(8'h1C, 32'h0000_0000);
    apb(1'b1, OFF_CUR_A0, {8'h00, 8'h24, 8'h05, run_val});
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i) cmd <= 2'(k);
      ec = (k == 0) ? 8'h05 : (k == 2 || run_val > 8'h23) ? 8'h23 : run_val;
      cyc(4);
      chk("cur_o", 32'(cur[7:0]), 32'(ec));
    end
    apb(1'b1, OFF_MSTEP, 32'h0000_0098);
    cyc(3);
    chk("mstep_o", 32'(mstep), 32'h0000_0088);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_003F);
    @(posedge clk_i) open <= 4'h1;
    lim_exp = 4'h1;
    cyc(4);
    chk("irq_o", 32'(irq), 32'h0000_0000);
    rd(OFF_IRQ_STAT, 32'h0000_0004);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
    cyc(3);
    chk("irq_o", 32'(irq), 32'h0000_0001);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_0004);
    cyc(3);
    chk("irq_o", 32'(irq), 32'h0000_0000);
    rd(OFF_STATUS, st(2'b11, 2'b00));
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    cyc(3);
    chk("limit_o", 32'(limit), 32'h0000_0002);
    @(posedge clk_i) open <= 4'h0;
    lim_exp = 4'h0;
    apb(1'b1, OFF_CTRL, 32'h0000_0050);
    cyc(3);
    chk("led", 32'({green, red}), 32'h0000_0003);
    chk("host_run_o", 32'(host_run), 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b1, OFF_IRQ_STAT, 32'h0000_003F);
    cyc(3);
    chk("led", 32'({green, red}), 32'h0000_0002);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i) fault[0] <= 3'(1 << k);
      @(posedge clk_i) fault[0] <= '0;
      cyc(5);
      chk("stage_on_o", 32'(stage_on), 32'h0000_0002);
      chk("led", 32'({green, red}), 32'h0000_0001);
      apb(1'b1, OFF_CTRL, 32'h0000_0080);
      cyc(3);
      chk("stage_on_o", 32'(stage_on), 32'h0000_0003);
    end
    @(posedge clk_i) fault[1] <= 3'b001;
    @(posedge clk_i) fault[1] <= '0;
    rd(OFF_STATUS, st(2'b01, 2'b10));
    addr0 = ~addr0;
    @(posedge clk_i) btn <= 1'b1;
    cyc(1);
    @(posedge clk_i) btn <= 1'b0;
    // The stages stay off for the whole restart delay and come on one edge after it ends.
    cyc(RC);
    chk("stage_on_o", 32'(stage_on), 32'h0000_0000);
    cyc(1);
    chk("stage_on_o", 32'(stage_on), 32'h0000_0003);
    rd(OFF_STATUS, st(2'b11, 2'b00));
    @(posedge clk_i) enable <= 1'b0;
    cyc(3);
    chk("stage_on_o", 32'(stage_on), 32'h0000_0000);
    @(posedge clk_i) enable <= 1'b1;
    @(posedge clk_i) local_mode <= 1'b1;
    t = 0;
    while (prog_start !== 1'b1 && t < 10) begin
      cyc(1);
      t++;
    end
    chk("prog_start_o", 32'(prog_start), 32'h0000_0001);
    cyc(2);
    chk("local_run_o", 32'(local_run), 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    cyc(2);
    chk("host_call_o", 32'(host_call), 32'h0000_0001);
    summarize();
  end
endmodule
